//--- rtl/brlg_pkg.sv
package brlg_pkg;
	localparam int          ADDR_W        = 8;
	// Register byte offsets
	localparam logic [7:0]  OFS_BRCTL     = 8'h00;
	localparam logic [7:0]  OFS_CMD       = 8'h04;
	localparam logic [7:0]  OFS_IOWIN     = 8'h08;
	localparam logic [7:0]  OFS_STAT      = 8'h0C;
	localparam logic [7:0]  OFS_CLR       = 8'h10;
	localparam logic [7:0]  OFS_IEN       = 8'h14;
	// Bridge control field positions
	localparam int          BC_PERR       = 0;
	localparam int          BC_SERR       = 1;
	localparam int          BC_ALIAS      = 2;
	localparam int          BC_VGA        = 3;
	// Command field positions
	localparam int          CM_IO         = 0;
	localparam int          CM_MEM        = 1;
	localparam int          CM_SERR       = 8;
	// Status field positions and reset values
	localparam int          ST_SERR       = 0;
	localparam int          ST_PERR       = 1;
	localparam logic [1:0]  STAT_RST      = 2'h0;
	localparam logic [15:0] IO_BASE_RST   = 16'hFFFF;
	localparam logic [15:0] IO_LIMIT_RST  = 16'h0000;
	// AXI responses
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_DECERR   = 2'h3;
	// Legacy VGA ranges
	localparam logic [63:0] VGA_MEM_LO    = 64'h0000_0000_000A_0000;
	localparam logic [63:0] VGA_MEM_HI    = 64'h0000_0000_000B_FFFF;
	localparam logic [63:0] VGA_IOA_LO    = 64'h0000_0000_0000_03B0;
	localparam logic [63:0] VGA_IOA_HI    = 64'h0000_0000_0000_03BB;
	localparam logic [63:0] VGA_IOB_LO    = 64'h0000_0000_0000_03C0;
	localparam logic [63:0] VGA_IOB_HI    = 64'h0000_0000_0000_03DF;

	typedef struct packed {
		logic        valid;  // Request present
		logic        is_io;  // I/O space, else memory
		logic [63:0] addr;   // Byte address
	} brlg_req_type;

	typedef struct packed {
		logic        vga;       // vga_window_forward_en
		logic        alias_blk; // legacy_alias_block_en
		logic        serr_fwd;  // system_error_forward_en
		logic        perr_rep;  // parity_error_report_en
		logic        mem_en;    // Memory space enable
		logic        io_en;     // I/O space enable
		logic        serr_en;   // Command SERR enable
		logic [15:0] io_base;   // I/O window base
		logic [15:0] io_limit;  // I/O window limit
	} brlg_ctrl_type;

	// Inclusive range test
	function automatic logic brlg_in_span(input logic [63:0] a,
		input logic [63:0] lo, input logic [63:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : brlg_in_span
endpackage : brlg_pkg

//--- rtl/brlg_decode.sv
`timescale 1ns/10ps
module brlg_decode
	import brlg_pkg::*;
(
	input  wire brlg_pkg::brlg_ctrl_type ctrl,   // Live controls
	input  wire brlg_pkg::brlg_req_type  dn,     // Downstream request
	input  wire brlg_pkg::brlg_req_type  up,     // Upstream request
	output logic                         dn_fwd, // Forward to secondary
	output logic                         up_fwd  // Forward to primary
);
	logic        dn_low;
	logic        vga_io;
	logic        vga_mem_dn;
	logic        vga_mem_up;
	logic        in_win;
	logic        alias_hit;
	logic [63:0] io_alias;

	// Address classification
	always_comb begin
		dn_low     = (dn.addr[63:16] == 48'h0000_0000_0000);
		io_alias   = {54'h0, dn.addr[9:0]};
		vga_io     = dn_low && (brlg_in_span(io_alias, VGA_IOA_LO, VGA_IOA_HI)
			|| brlg_in_span(io_alias, VGA_IOB_LO, VGA_IOB_HI));
		vga_mem_dn = brlg_in_span(dn.addr, VGA_MEM_LO, VGA_MEM_HI);
		vga_mem_up = brlg_in_span(up.addr, VGA_MEM_LO, VGA_MEM_HI);
		in_win     = dn_low && brlg_in_span(dn.addr, {48'h0, ctrl.io_base},
			{48'h0, ctrl.io_limit});
		alias_hit  = ctrl.alias_blk && in_win && dn_low
			&& (dn.addr[9:8] != 2'h0);
	end

	// Forwarding decisions
	always_comb begin
		if (dn.is_io) begin
			dn_fwd = ctrl.io_en && ((ctrl.vga && vga_io)
				|| (in_win && !alias_hit));
		end else begin
			dn_fwd = ctrl.mem_en && ctrl.vga && vga_mem_dn;
		end
		up_fwd = !up.is_io && !ctrl.vga && vga_mem_up;
	end
endmodule : brlg_decode

//--- rtl/brlg_top.sv
`timescale 1ns/10ps
module brlg_top
	import brlg_pkg::*;
(
	input  wire logic                         CLK,           // Clock
	input  wire logic                         RST,           // Reset
	input  wire logic                         S_AXI_AWVALID, // Write addr
	output logic                              S_AXI_AWREADY, // Addr taken
	input  wire logic [brlg_pkg::ADDR_W-1:0]  S_AXI_AWADDR,  // Byte addr
	input  wire logic                         S_AXI_WVALID,  // Write data
	output logic                              S_AXI_WREADY,  // Data taken
	input  wire logic [31:0]                  S_AXI_WDATA,   // Data
	input  wire logic [3:0]                   S_AXI_WSTRB,   // Byte lanes
	output logic                              S_AXI_BVALID,  // Response
	input  wire logic                         S_AXI_BREADY,  // Resp taken
	output logic [1:0]                        S_AXI_BRESP,   // Resp code
	input  wire logic                         S_AXI_ARVALID, // Read addr
	output logic                              S_AXI_ARREADY, // Addr taken
	input  wire logic [brlg_pkg::ADDR_W-1:0]  S_AXI_ARADDR,  // Byte addr
	output logic                              S_AXI_RVALID,  // Read data
	input  wire logic                         S_AXI_RREADY,  // Data taken
	output logic [31:0]                       S_AXI_RDATA,   // Data
	output logic [1:0]                        S_AXI_RRESP,   // Resp code
	input  wire brlg_pkg::brlg_req_type       DN_REQ,        // From primary
	output logic                              DN_ACK,        // Decided
	output logic                              DN_FWD,        // Go secondary
	input  wire brlg_pkg::brlg_req_type       UP_REQ,        // From second.
	output logic                              UP_ACK,        // Decided
	output logic                              UP_FWD,        // Go primary
	input  wire logic                         SEC_SERR_N,    // Sec. SERR
	output logic                              MSG_SERR,      // Send message
	input  wire logic [1:0]                   SEC_PERR,      // Par errors
	output logic                              PERR_REPORT,   // Report error
	input  wire logic [31:0]                  SEC_AD,        // Driven AD
	input  wire logic [3:0]                   SEC_CBE_N,     // Driven C/BE
	output logic                              SEC_PAR,       // Even parity
	output logic                              IRQ            // Interrupt
);
	typedef struct packed {
		brlg_ctrl_type     ctrl;     // Control registers
		logic              aw_got;   // Write address held
		logic              w_got;    // Write data held
		logic [ADDR_W-1:0] awaddr;   // Held write address
		logic [31:0]       wdata;    // Held write data
		logic [3:0]        wstrb;    // Held strobes
		logic              bvalid;   // Write response pending
		logic [1:0]        bresp;    // Write response code
		logic              rvalid;   // Read data pending
		logic [31:0]       rdata;    // Read data
		logic [1:0]        rresp;    // Read response code
		logic [1:0]        status;   // Sticky events
		logic [1:0]        irq_en;   // Event enables
		logic              serr_q;   // SERR seen last cycle
		logic              dn_ack;   // Downstream decided
		logic              dn_fwd;   // Downstream verdict
		logic              up_ack;   // Upstream decided
		logic              up_fwd;   // Upstream verdict
		logic              msg_serr; // Message pulse
		logic              perr_out; // Report pulse
		logic              par;      // Generated parity
	} brlg_state_type;

	brlg_state_type st;
	brlg_state_type next_st;
	logic           dec_dn_fwd;
	logic           dec_up_fwd;
	logic           aw_take;
	logic           w_take;
	logic           ar_take;
	logic           serr_now;
	logic [1:0]     ev;
	logic [31:0]    cur;
	logic [31:0]    upd;

	// Merge written byte lanes into an old value
	function automatic logic [31:0] brlg_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : brlg_merge

	// Register image at an offset
	function automatic logic [31:0] brlg_image(input brlg_state_type s,
		input logic [ADDR_W-1:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			OFS_BRCTL: begin
				v[BC_VGA]   = s.ctrl.vga;
				v[BC_ALIAS] = s.ctrl.alias_blk;
				v[BC_SERR]  = s.ctrl.serr_fwd;
				v[BC_PERR]  = s.ctrl.perr_rep;
			end
			OFS_CMD: begin
				v[CM_IO]   = s.ctrl.io_en;
				v[CM_MEM]  = s.ctrl.mem_en;
				v[CM_SERR] = s.ctrl.serr_en;
			end
			OFS_IOWIN: v = {s.ctrl.io_limit, s.ctrl.io_base};
			OFS_STAT:  v[1:0] = s.status;
			OFS_IEN:   v[1:0] = s.irq_en;
			default:   v = 32'h0000_0000;
		endcase
		return v;
	endfunction : brlg_image

	// Known register offset
	function automatic logic brlg_mapped(input logic [ADDR_W-1:0] a);
		return (a == OFS_BRCTL) || (a == OFS_CMD) || (a == OFS_IOWIN)
			|| (a == OFS_STAT) || (a == OFS_CLR) || (a == OFS_IEN);
	endfunction : brlg_mapped

	brlg_decode u_decode (
		.ctrl   (st.ctrl),
		.dn     (DN_REQ),
		.up     (UP_REQ),
		.dn_fwd (dec_dn_fwd),
		.up_fwd (dec_up_fwd)
	);

	// Bus handshakes
	assign S_AXI_AWREADY = !st.aw_got && !st.bvalid;
	assign S_AXI_WREADY  = !st.w_got && !st.bvalid;
	assign S_AXI_ARREADY = !st.rvalid;
	assign aw_take       = S_AXI_AWVALID && S_AXI_AWREADY;
	assign w_take        = S_AXI_WVALID && S_AXI_WREADY;
	assign ar_take       = S_AXI_ARVALID && S_AXI_ARREADY;

	// Event detection
	assign serr_now = !SEC_SERR_N;
	assign ev[ST_SERR] = serr_now && !st.serr_q && st.ctrl.serr_fwd
		&& st.ctrl.serr_en;
	assign ev[ST_PERR] = st.ctrl.perr_rep && (SEC_PERR != 2'h0);

	// Next state
	always_comb begin
		next_st = st;
		cur     = 32'h0000_0000;
		upd     = 32'h0000_0000;
		if (aw_take) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = S_AXI_AWADDR;
		end
		if (w_take) begin
			next_st.w_got = 1'b1;
			next_st.wdata = S_AXI_WDATA;
			next_st.wstrb = S_AXI_WSTRB;
		end
		if (st.bvalid && S_AXI_BREADY) begin
			next_st.bvalid = 1'b0;
		end
		// Perform a write once address and data are both held
		if (st.aw_got && st.w_got) begin
			next_st.aw_got = 1'b0;
			next_st.w_got  = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = brlg_mapped(st.awaddr) ? RESP_OKAY : RESP_DECERR;
			cur = brlg_image(st, st.awaddr);
			upd = brlg_merge(cur, st.wdata, st.wstrb);
			case (st.awaddr)
				OFS_BRCTL: begin
					next_st.ctrl.vga       = upd[BC_VGA];
					next_st.ctrl.alias_blk = upd[BC_ALIAS];
					next_st.ctrl.serr_fwd  = upd[BC_SERR];
					next_st.ctrl.perr_rep  = upd[BC_PERR];
				end
				OFS_CMD: begin
					next_st.ctrl.io_en   = upd[CM_IO];
					next_st.ctrl.mem_en  = upd[CM_MEM];
					next_st.ctrl.serr_en = upd[CM_SERR];
				end
				OFS_IOWIN: begin
					next_st.ctrl.io_base  = upd[15:0];
					next_st.ctrl.io_limit = upd[31:16];
				end
				OFS_CLR: begin
					if (st.wstrb[0]) begin
						next_st.status = st.status & ~st.wdata[1:0];
					end
				end
				OFS_IEN:  next_st.irq_en = upd[1:0];
				default:  next_st.bresp = brlg_mapped(st.awaddr)
					? RESP_OKAY : RESP_DECERR;
			endcase
		end
		// Reads answer one cycle after the address is taken
		if (st.rvalid && S_AXI_RREADY) begin
			next_st.rvalid = 1'b0;
		end
		if (ar_take) begin
			next_st.rvalid = 1'b1;
			next_st.rdata  = brlg_image(st, S_AXI_ARADDR);
			next_st.rresp  = brlg_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_DECERR;
		end
		// Sticky events, set wins over clear
		next_st.status   = next_st.status | ev;
		next_st.serr_q   = serr_now;
		next_st.msg_serr = ev[ST_SERR];
		next_st.perr_out = ev[ST_PERR];
		next_st.par      = ^{SEC_AD, SEC_CBE_N};
		// Forwarding verdicts
		next_st.dn_ack = DN_REQ.valid;
		next_st.up_ack = UP_REQ.valid;
		if (DN_REQ.valid) begin
			next_st.dn_fwd = dec_dn_fwd;
		end
		if (UP_REQ.valid) begin
			next_st.up_fwd = dec_up_fwd;
		end
	end

	// State register
	always_ff @(posedge CLK) begin
		if (RST) begin
			st <= '0;
			st.ctrl.io_base  <= IO_BASE_RST;
			st.ctrl.io_limit <= IO_LIMIT_RST;
			st.status        <= STAT_RST;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign S_AXI_BVALID = st.bvalid;
	assign S_AXI_BRESP  = st.bresp;
	assign S_AXI_RVALID = st.rvalid;
	assign S_AXI_RDATA  = st.rdata;
	assign S_AXI_RRESP  = st.rresp;
	assign DN_ACK       = st.dn_ack;
	assign DN_FWD       = st.dn_fwd;
	assign UP_ACK       = st.up_ack;
	assign UP_FWD       = st.up_fwd;
	assign MSG_SERR     = st.msg_serr;
	assign PERR_REPORT  = st.perr_out;
	assign SEC_PAR      = st.par;
	assign IRQ          = |(st.status & st.irq_en);

	// Checks
	vga_mem_fwd_a: assert property (@(posedge CLK) disable iff (RST)
		DN_REQ.valid && !DN_REQ.is_io && st.ctrl.vga && st.ctrl.mem_en
		&& DN_REQ.addr >= VGA_MEM_LO && DN_REQ.addr <= VGA_MEM_HI
		|=> DN_ACK && DN_FWD)
		else $error("VGA memory access not forwarded");
	vga_io_fwd_a: assert property (@(posedge CLK) disable iff (RST)
		DN_REQ.valid && DN_REQ.is_io && st.ctrl.vga && st.ctrl.io_en
		&& DN_REQ.addr[63:16] == 48'h0 && DN_REQ.addr[9:0] >= 10'h3C0
		&& DN_REQ.addr[9:0] <= 10'h3DF |=> DN_FWD)
		else $error("VGA I/O alias not forwarded");
	space_gate_a: assert property (@(posedge CLK) disable iff (RST)
		DN_REQ.valid && (DN_REQ.is_io ? !st.ctrl.io_en : !st.ctrl.mem_en)
		|=> !DN_FWD)
		else $error("Forwarded with space disabled");
	vga_up_fwd_a: assert property (@(posedge CLK) disable iff (RST)
		UP_REQ.valid && !UP_REQ.is_io && !st.ctrl.vga
		&& UP_REQ.addr >= VGA_MEM_LO && UP_REQ.addr <= VGA_MEM_HI
		|=> UP_ACK && UP_FWD)
		else $error("VGA memory not sent upstream");
	alias_block_a: assert property (@(posedge CLK) disable iff (RST)
		DN_REQ.valid && DN_REQ.is_io && st.ctrl.alias_blk && !st.ctrl.vga
		&& DN_REQ.addr[9:8] != 2'h0 |=> !DN_FWD)
		else $error("ISA alias forwarded");
	alias_scope_a: assert property (@(posedge CLK) disable iff (RST)
		DN_REQ.valid && DN_REQ.is_io && st.ctrl.io_en
		&& DN_REQ.addr[63:16] == 48'h0 && DN_REQ.addr[9:8] == 2'h0
		&& DN_REQ.addr[15:0] >= st.ctrl.io_base
		&& DN_REQ.addr[15:0] <= st.ctrl.io_limit |=> DN_FWD)
		else $error("Window access wrongly blocked");
	up_io_block_a: assert property (@(posedge CLK) disable iff (RST)
		UP_REQ.valid && UP_REQ.is_io |=> UP_ACK && !UP_FWD)
		else $error("I/O forwarded upstream");
	serr_msg_a: assert property (@(posedge CLK) disable iff (RST)
		MSG_SERR |-> $past(!SEC_SERR_N) && $past(st.ctrl.serr_fwd)
		&& $past(st.ctrl.serr_en) && $past(SEC_SERR_N, 2))
		else $error("System error message without cause");
	perr_ignore_a: assert property (@(posedge CLK) disable iff (RST)
		!st.ctrl.perr_rep |=> !PERR_REPORT)
		else $error("Parity error reported while off");
	par_gen_a: assert property (@(posedge CLK) disable iff (RST)
		1'b1 |=> SEC_PAR == $past(^{SEC_AD, SEC_CBE_N}))
		else $error("Parity not generated");
	perr_report_a: assert property (@(posedge CLK) disable iff (RST)
		st.ctrl.perr_rep && SEC_PERR != 2'h0 |=> PERR_REPORT
		##0 st.status[ST_PERR])
		else $error("Parity error not reported");
endmodule : brlg_top

//--- tb/brlg_sec_agent.sv
`timescale 1ns/10ps
// Secondary bus agent: raises SERR and parity errors, drives AD/CBE
module brlg_sec_agent (
	input  wire logic        clk,    // Bus clock
	output logic             serr_n, // SERR, pulled up when idle
	output logic [1:0]       perr,   // Address/data parity errors
	output logic [31:0]      ad,     // Word on AD lines
	output logic [3:0]       cbe_n   // Word on C/BE lines
);
	// Idle bus: SERR at its pull-up level
	initial begin
		serr_n = 1'b1;
		perr   = 2'h0;
		ad     = 32'h0000_0000;
		cbe_n  = 4'hF;
	end

	// Hold SERR low for n cycles, then let the pull-up restore it
	task automatic serr_pulse(input int n);
		@(posedge clk);
		serr_n <= 1'b0;
		repeat (n) @(posedge clk);
		serr_n <= 1'b1;
	endtask : serr_pulse

	// Flag parity errors for one cycle while a word sits on the bus
	task automatic perr_pulse(input logic [1:0] e, input logic [31:0] d,
		input logic [3:0] c);
		@(posedge clk);
		perr  <= e;
		ad    <= d;
		cbe_n <= c;
		@(posedge clk);
		perr  <= 2'h0;
	endtask : perr_pulse
endmodule : brlg_sec_agent

//--- tb/brlg_top_tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
	begin \
		num_checks++; \
		if ((got) !== (ex)) begin \
			error_cnt++; \
			$display("Error %s expected %h seen %h", nm, ex, got); \
		end \
	end

module brlg_top_tb;
	import brlg_pkg::*;
	logic               clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic               awready, wready, bvalid, arready, rvalid, irq;
	logic               dn_ack, dn_fwd, up_ack, up_fwd, msg_serr, perr_rep;
	logic               serr_n, sec_par;
	logic [7:0]         awaddr, araddr;
	logic [31:0]        wdata, rdata, ad;
	logic [1:0]         bresp, rresp, perr;
	logic [3:0]         cbe_n;
	brlg_req_type       dn_req, up_req;
	int                 error_cnt, num_checks, n_msg, n_rep;

	brlg_top i_dut (.CLK(clk), .RST(rst),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .DN_REQ(dn_req),
		.DN_ACK(dn_ack), .DN_FWD(dn_fwd), .UP_REQ(up_req), .UP_ACK(up_ack),
		.UP_FWD(up_fwd), .SEC_SERR_N(serr_n), .MSG_SERR(msg_serr),
		.SEC_PERR(perr), .PERR_REPORT(perr_rep), .SEC_AD(ad),
		.SEC_CBE_N(cbe_n), .SEC_PAR(sec_par), .IRQ(irq));

	brlg_sec_agent i_agent (.clk(clk), .serr_n(serr_n), .perr(perr),
		.ad(ad), .cbe_n(cbe_n));

	// Clock
	always #5 clk = ~clk;

	// Count message and report pulses
	always @(posedge clk) begin
		if (msg_serr === 1'b1) n_msg++;
		if (perr_rep === 1'b1) n_rep++;
	end

	// Verdict and end of run
	task automatic end_sim();
		if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	task automatic hang(input string nm);
		error_cnt++;
		$display("Error %s expected answer seen timeout", nm);
		end_sim();
	endtask : hang

	// Register write; handshakes sampled at the falling edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] ex);
		logic ta, tw, tb;
		logic [1:0] r;
		tb = 1'b0;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		bready  <= 1'b1;
		for (int n = 0; n < 20 && !tb; n++) begin
			@(negedge clk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid & bready;
			r  = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
		if (!tb) hang("bvalid");
		`CHK("bresp", ex, r);
	endtask : wr

	// Register read and compare
	task automatic rd(input logic [7:0] a, input logic [31:0] ex,
		input logic [1:0] exr);
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		tr = 1'b0;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		for (int n = 0; n < 20 && !tr; n++) begin
			@(negedge clk);
			ta = arvalid & arready;
			tr = rvalid & rready;
			d  = rdata;
			r  = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
		if (!tr) hang("rvalid");
		`CHK("rdata", ex, d);
		`CHK("rresp", exr, r);
	endtask : rd

	task automatic ctl(input logic [31:0] bc, input logic [31:0] cm);
		wr(OFS_BRCTL, bc, RESP_OKAY);
		wr(OFS_CMD, cm, RESP_OKAY);
	endtask : ctl

	// One request on either side, verdict one cycle later
	task automatic dec(input int up, input int io, input logic [31:0] a,
		input int ex);
		@(posedge clk);
		if (up != 0) up_req <= '{1'b1, io[0], {32'h0000_0000, a}};
		else dn_req <= '{1'b1, io[0], {32'h0000_0000, a}};
		@(posedge clk);
		dn_req.valid <= 1'b0;
		up_req.valid <= 1'b0;
		#1;
		`CHK("ack", 1'b1, (up != 0) ? up_ack : dn_ack);
		`CHK("fwd", ex[0], (up != 0) ? up_fwd : dn_fwd);
	endtask : dec

	// Reset values, unmapped place, read-only bits
	task automatic t_regs();
		rd(OFS_BRCTL, 32'h0000_0000, RESP_OKAY);
		rd(OFS_CMD, 32'h0000_0000, RESP_OKAY);
		rd(OFS_IOWIN, 32'h0000_FFFF, RESP_OKAY);
		rd(OFS_STAT, 32'h0000_0000, RESP_OKAY);
		rd(OFS_IEN, 32'h0000_0000, RESP_OKAY);
		rd(8'h18, 32'h0000_0000, RESP_DECERR);
		wr(8'h18, 32'hFFFF_FFFF, RESP_DECERR);
		wr(OFS_BRCTL, 32'hFFFF_FFFF, RESP_OKAY);
		rd(OFS_BRCTL, 32'h0000_000F, RESP_OKAY);
		rd(OFS_CLR, 32'h0000_0000, RESP_OKAY);
	endtask : t_regs

	// VGA memory and I/O windows downstream
	task automatic t_vga();
		ctl(32'h0000_0008, 32'h0000_0002);
		dec(0, 0, 32'h000A_0000, 1);
		dec(0, 0, 32'h0009_FFFF, 0);
		dec(0, 0, 32'h000B_FFFF, 1);
		dec(0, 0, 32'h000C_0000, 0);
		dec(0, 1, 32'h0000_03B0, 0);
		ctl(32'h0000_0008, 32'h0000_0001);
		dec(0, 0, 32'h000A_0000, 0);
		dec(0, 1, 32'h0000_03B0, 1);
		dec(0, 1, 32'h0000_03BB, 1);
		dec(0, 1, 32'h0000_03BC, 0);
		dec(0, 1, 32'h0000_03C0, 1);
		dec(0, 1, 32'h0000_03DF, 1);
		dec(0, 1, 32'h0000_FFDF, 1);
		dec(0, 1, 32'h0001_03B0, 0);
		ctl(32'h0000_0000, 32'h0000_0003);
		dec(0, 0, 32'h000A_0000, 0);
		dec(0, 1, 32'h0000_03C0, 0);
	endtask : t_vga

	// Upstream forwarding of the legacy ranges
	task automatic t_up();
		ctl(32'h0000_0000, 32'h0000_0000);
		dec(1, 0, 32'h000A_0000, 1);
		dec(1, 0, 32'h000B_FFFF, 1);
		dec(1, 0, 32'h000C_0000, 0);
		dec(1, 1, 32'h0000_03B0, 0);
		ctl(32'h0000_000C, 32'h0000_0003);
		dec(1, 0, 32'h000A_0000, 0);
		dec(1, 1, 32'h0000_1100, 0);
	endtask : t_up

	// Alias blocking inside an I/O window at 1000h..1FFFh
	task automatic t_alias();
		wr(OFS_IOWIN, 32'h1FFF_1000, RESP_OKAY);
		ctl(32'h0000_0000, 32'h0000_0001);
		dec(0, 1, 32'h0000_1100, 1);
		ctl(32'h0000_0004, 32'h0000_0001);
		dec(0, 1, 32'h0000_1100, 0);
		dec(0, 1, 32'h0000_13FF, 0);
		dec(0, 1, 32'h0000_1000, 1);
		dec(0, 1, 32'h0000_10FF, 1);
		dec(0, 1, 32'h0000_1400, 1);
		dec(0, 1, 32'h0000_2000, 0);
		dec(0, 1, 32'h0001_1000, 0);
	endtask : t_alias

	// SERR forwarding, status, interrupt raise/mask/clear
	task automatic t_serr();
		ctl(32'h0000_0002, 32'h0000_0100);
		n_msg = 0;
		i_agent.serr_pulse(3);
		repeat (3) @(posedge clk);
		`CHK("msg", 1, n_msg);
		rd(OFS_STAT, 32'h0000_0001, RESP_OKAY);
		`CHK("irq", 1'b0, irq);
		wr(OFS_IEN, 32'h0000_0001, RESP_OKAY);
		#1;
		`CHK("irq", 1'b1, irq);
		wr(OFS_CLR, 32'h0000_0001, RESP_OKAY);
		#1;
		`CHK("irq", 1'b0, irq);
		ctl(32'h0000_0002, 32'h0000_0000);
		i_agent.serr_pulse(2);
		ctl(32'h0000_0000, 32'h0000_0100);
		i_agent.serr_pulse(2);
		repeat (3) @(posedge clk);
		`CHK("msg", 1, n_msg);
		rd(OFS_STAT, 32'h0000_0000, RESP_OKAY);
	endtask : t_serr

	// Parity reporting off, then on; parity always generated
	task automatic t_perr();
		ctl(32'h0000_0000, 32'h0000_0000);
		n_rep = 0;
		i_agent.perr_pulse(2'h3, 32'h1234_5678, 4'h0);
		repeat (2) @(posedge clk);
		`CHK("rep", 0, n_rep);
		`CHK("par", ^{32'h1234_5678, 4'h0}, sec_par);
		ctl(32'h0000_0001, 32'h0000_0000);
		i_agent.perr_pulse(2'h1, 32'h0000_0001, 4'hE);
		i_agent.perr_pulse(2'h2, 32'h0000_0001, 4'hE);
		repeat (2) @(posedge clk);
		`CHK("rep", 2, n_rep);
		`CHK("par", ^{32'h0000_0001, 4'hE}, sec_par);
		rd(OFS_STAT, 32'h0000_0002, RESP_OKAY);
		wr(OFS_IEN, 32'h0000_0002, RESP_OKAY);
		#1;
		`CHK("irq", 1'b1, irq);
		wr(OFS_CLR, 32'h0000_0002, RESP_OKAY);
		#1;
		`CHK("irq", 1'b0, irq);
	endtask : t_perr

	// Main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		dn_req = '0;
		up_req = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_vga();
		t_up();
		t_alias();
		t_serr();
		t_perr();
		end_sim();
	end

	// Watchdog
	initial begin
		#500_000;
		hang("run");
	end
endmodule : brlg_top_tb
